// ---- rtl/channel_interp.sv ----
`timescale 1ns/1ps
`include "sincos_defs.svh"
module channel_interp #(
  parameter int CNT_W = 24
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // sampled angle and setup
  input  wire logic [15:0]       phase,
  input  wire logic [13:0]       interpolation_rate,
  input  wire logic [1:0]        div_sel,
  input  wire logic              calib,
  // results
  output logic      [CNT_W-1:0]  count,
  output sincos_pkg::quad_t      quad,
  output logic      [13:0]       fine_idx,
  output logic                   rate_ok
);
  import sincos_pkg::*;

  logic [13:0]      pos_r;
  logic [13:0]      pos_nxt;
  logic [1:0]       q_r;
  logic [1:0]       q_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic             init_r;
  quad_t            quad_r;
  quad_t            quad_nxt;

  wire [29:0] prod    = frac_scale(phase, interpolation_rate);
  wire [13:0] fine    = prod[29:16];
  wire [13:0] rate_d  = interpolation_rate >> div_sel;
  wire [13:0] target  = fine >> div_sel;
  wire [13:0] half_d  = rate_d >> 1;
  wire [13:0] last    = rate_d - 14'h1;
  // forward distance modulo the divided rate
  wire [13:0] fwd     = (target >= pos_r) ? target - pos_r : target + rate_d - pos_r;
  // resync without counting after reset or when the position lies at or beyond the divided rate
  wire        resync  = init_r || (pos_r >= rate_d);
  wire        step_up = !resync && fwd != 14'h0 && fwd <= half_d;
  wire        step_dn = !resync && fwd > half_d;

  assign pos_nxt = resync  ? target :
                   step_up ? ((pos_r == last) ? 14'h0 : pos_r + 14'h1) :
                   step_dn ? ((pos_r == 14'h0) ? last : pos_r - 14'h1) : pos_r;
  assign q_nxt   = step_up ? q_r + 2'h1 : step_dn ? q_r - 2'h1 : q_r;

  // one quadrature step per increment, gray sequence 00,10,11,01
  assign quad_nxt.a = calib ? ~phase[15] : q_nxt[0] ^ q_nxt[1];
  assign quad_nxt.b = calib ? ~(phase[15] ^ phase[14]) : q_nxt[1];
  assign quad_nxt.z = (pos_nxt == 14'h0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_r  <= 14'h0;
      q_r    <= 2'h0;
      cnt_r  <= '0;
      init_r <= 1'b1;
      quad_r <= '0;
    end else begin
      pos_r  <= pos_nxt;
      q_r    <= q_nxt;
      init_r <= 1'b0;
      quad_r <= quad_nxt;
      if (step_up) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end else if (step_dn) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  assign count    = cnt_r;
  assign quad     = quad_r;
  assign fine_idx = fine;
  assign rate_ok  = (rate_d[`QUAD_ALIGN] == 2'h0);

  a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(cnt_r) |-> (cnt_r - $past(cnt_r) == CNT_W'(1)) ||
                        ($past(cnt_r) - cnt_r == CNT_W'(1)))
    else $error("counter moved by more than one");

  a_count_up: assert property (@(posedge clk) disable iff (!rst_n)
    step_up |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("counter missed an up step");

  a_quad_gray: assert property (@(posedge clk) disable iff (!rst_n)
    (!calib && $past(!calib)) ##1 !calib
    |-> !($changed(quad_r.a) && $changed(quad_r.b)))
    else $error("both quadrature lines switched together");

  a_calib_test: assert property (@(posedge clk) disable iff (!rst_n)
    calib |=> quad_r.a == !$past(phase[15]))
    else $error("calibration test signal wrong");

endmodule

// ---- rtl/coef_mem.sv ----
`timescale 1ns/1ps
module coef_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read ports
  input  wire logic [AW-1:0]    addr_a,
  output logic      [WIDTH-1:0] data_a,
  input  wire logic [AW-1:0]    addr_b,
  output logic      [WIDTH-1:0] data_b
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // reset stands in for the load of the stored image
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      data_a <= '0;
      data_b <= '0;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      data_a <= mem_r[addr_a];
      data_b <= mem_r[addr_b];
    end
  end

  a_mem_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr_a == wr_addr) ##1 (!wr_en && addr_a == $past(addr_a))
    |=> data_a == $past(wr_data, 2))
    else $error("coefficient readback mismatch");

endmodule

// ---- rtl/sincos_defs.svh ----
`ifndef SINCOS_DEFS_SVH
`define SINCOS_DEFS_SVH

// register byte addresses
`define ADR_CONFIG      8'h00
`define ADR_INTERPOLATION_RATE       8'h04
`define ADR_SERIAL      8'h08
`define ADR_CNT_ONE     8'h0c
`define ADR_CNT_TWO     8'h10
`define ADR_POSITION    8'h14
`define ADR_STATUS      8'h18
`define COEF_REGION     2'h1

// primary_config_word fields
`define CFG_MODE        3:0
`define CFG_DIV1        5:4
`define CFG_DIV2        7:6
`define CFG_SPLIT       8
`define CFG_VDIV        10:9
`define CFG_W           11
`define CFG_RESET       11'h600

// interpolation_rate limits
`define INTERPOLATION_RATE_W         14
`define INTERPOLATION_RATE_RESET     14'h0800
`define INTERPOLATION_RATE_MIN       14'h0100
`define INTERPOLATION_RATE_MAX       14'h2000
`define INTERPOLATION_RATE_DIV8_MAX  14'h1000
`define INTERPOLATION_RATE_ALIGN     2:0
`define QUAD_ALIGN      1:0

// modes, sources, arithmetic
`define MODE_CALIB      4'h5
`define VDIV_BASE       3'h3
`define FRAC_HALF       31'h0000_8000
`define SERIAL_RESET    2'h0
`define SRC_ABS         2'h0
`define SRC_CH1         2'h1
`define SRC_CH2         2'h2
`define SRC_BOTH        2'h3

// status bits
`define STAT_RATE_OK    0
`define STAT_Q1_OK      1
`define STAT_Q2_OK      2
`define STAT_CALIB      3

`endif

// ---- rtl/sincos_interpolation_vernier.sv ----
// Functional notes
// - split each input period into increments; expose phase and count values; here only counts and position are readable, no phase.
// - drive quadrature pair a quarter period apart plus index output per channel.
// - derive absolute position by vernier combination of both channel phases.
// - sixteen stored correction coefficients trim the vernier phase difference.
// - four-bit mode field; X000 for normal uses, 0101 for calibration.
// - calibration puts test signals on both quadrature outputs; counters keep running.
// - each channel keeps its own counter, readable in its own count register.
// - outside calibration each quadrature pair carries its own channel increments.
// - independent-sensor use reports channel one, two or both counts as position.
// - two-bit position source select chooses the position register content.
// - interpolation rate 256 to 8192, multiple of eight; otherwise flagged.
// - vernier pitch equals interpolation rate divided by 8, 16, 32 or 64.
// - counters and quadrature run at base rate over a per-channel divider.
// - per-channel divider factors are 1, 2, 4 or 8.
// - split bit 0 shares divider one; split bit 1 gives each its own.
// - divided rate equals quadrature transitions and counter steps per period.
// - quadrature square periods per input period are a quarter of divided rate.
`timescale 1ns/1ps
`include "sincos_defs.svh"
module sincos_interpolation_vernier #(
  parameter int POS_W = 24
) (
  // clock and reset
  input  wire logic         SYS_CLK,
  input  wire logic         RESETN,
  // wishbone slave
  input  wire logic         WB_CYC_I,
  input  wire logic         WB_STB_I,
  input  wire logic         WB_WE_I,
  input  wire logic [7:0]   WB_ADR_I,
  input  wire logic [3:0]   WB_SEL_I,
  input  wire logic [31:0]  WB_DAT_I,
  output logic      [31:0]  WB_DAT_O,
  output logic              WB_ACK_O,
  // sampled angles from the front end
  input  wire logic [15:0]  PHASE_CH_ONE,
  input  wire logic [15:0]  PHASE_CH_TWO,
  // square-wave outputs
  output sincos_pkg::quad_t QUADRATURE_OUTPUTS_CH_ONE,
  output sincos_pkg::quad_t QUADRATURE_OUTPUTS_CH_TWO
);
  import sincos_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [`CFG_W-1:0]   primary_config_word_r;
  logic [`CFG_W-1:0]   primary_config_word_nxt;
  logic [`INTERPOLATION_RATE_W-1:0] interpolation_rate_r;
  logic [`INTERPOLATION_RATE_W-1:0] interpolation_rate_nxt;
  logic [1:0]          serial_output_config_r;
  logic [1:0]          serial_output_config_nxt;
  logic [POS_W-1:0]    position_result_r;
  logic [POS_W-1:0]    position_result_nxt;

  wire [3:0] mode = primary_config_word_r[`CFG_MODE];
  wire       calib = (mode == `MODE_CALIB);
  wire [1:0] count_rate_divider_ch_one = primary_config_word_r[`CFG_DIV1];
  wire [1:0] count_rate_divider_ch_two = primary_config_word_r[`CFG_DIV2];
  wire       divider_split_select = primary_config_word_r[`CFG_SPLIT];
  wire [1:0] vernier_div = primary_config_word_r[`CFG_VDIV];
  wire [1:0] position_source_select = serial_output_config_r;

  // second channel falls back to the first divider unless split
  wire [1:0] div_two_eff = divider_split_select ? count_rate_divider_ch_two
                                                : count_rate_divider_ch_one;

  //////////////////////////////////////////////////////////////////////////////
  // rate checks

  // bad settings are still used; software reads the flags
  wire rate_in_range = (interpolation_rate_r >= `INTERPOLATION_RATE_MIN) &&
                       (interpolation_rate_r <= `INTERPOLATION_RATE_MAX);
  wire rate_aligned  = (interpolation_rate_r[`INTERPOLATION_RATE_ALIGN] == 3'h0);
  wire rate_div8_bad = (vernier_div == 2'h0) &&
                       (interpolation_rate_r > `INTERPOLATION_RATE_DIV8_MAX);
  wire rate_ok       = rate_in_range && rate_aligned && !rate_div8_bad;
  wire q1_ok;
  wire q2_ok;

  //////////////////////////////////////////////////////////////////////////////
  // channels

  logic [POS_W-1:0] channel_one_count;
  logic [POS_W-1:0] channel_two_count;
  logic [13:0]      fine_one;

  channel_interp #(
    .CNT_W (POS_W)
  ) u_ch_one (
    .clk      (SYS_CLK),
    .rst_n    (RESETN),
    .phase    (PHASE_CH_ONE),
    .interpolation_rate    (interpolation_rate_r),
    .div_sel  (count_rate_divider_ch_one),
    .calib    (calib),
    .count    (channel_one_count),
    .quad     (QUADRATURE_OUTPUTS_CH_ONE),
    .fine_idx (fine_one),
    .rate_ok  (q1_ok)
  );

  channel_interp #(
    .CNT_W (POS_W)
  ) u_ch_two (
    .clk      (SYS_CLK),
    .rst_n    (RESETN),
    .phase    (PHASE_CH_TWO),
    .interpolation_rate    (interpolation_rate_r),
    .div_sel  (div_two_eff),
    .calib    (calib),
    .count    (channel_two_count),
    .quad     (QUADRATURE_OUTPUTS_CH_TWO),
    .fine_idx (),
    .rate_ok  (q2_ok)
  );

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  bus_state_t bus_r;
  bus_state_t bus_nxt;
  logic       ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_word;
  logic [15:0] coef_bus;
  logic [15:0] coef_q;

  wire       req      = WB_CYC_I && WB_STB_I;
  wire [7:0] adr      = {WB_ADR_I[7:2], 2'b00};
  wire       coef_hit = (WB_ADR_I[7:6] == `COEF_REGION);
  // writes land on the edge at which the master sees ack high
  wire       wr_go    = (bus_r == BUS_ACK) && req && WB_WE_I;
  wire       rd_go    = (bus_r == BUS_WAIT) && req && !WB_WE_I;
  wire       coef_wr  = wr_go && coef_hit && (&WB_SEL_I[1:0]);

  // one wait state gives the coefficient memory its read cycle
  always_comb begin
    case (bus_r)
      BUS_IDLE: bus_nxt = req ? BUS_WAIT : BUS_IDLE;
      BUS_WAIT: bus_nxt = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  bus_nxt = BUS_IDLE;
      default:  bus_nxt = BUS_IDLE;
    endcase
  end

  wire [31:0] cfg_merge = byte_merge({21'h0, primary_config_word_r}, WB_DAT_I, WB_SEL_I);
  wire [31:0] rate_merge = byte_merge({18'h0, interpolation_rate_r}, WB_DAT_I, WB_SEL_I);
  wire [31:0] ser_merge = byte_merge({30'h0, serial_output_config_r}, WB_DAT_I, WB_SEL_I);

  assign primary_config_word_nxt  = (wr_go && adr == `ADR_CONFIG) ?
                                    cfg_merge[`CFG_W-1:0] : primary_config_word_r;
  assign interpolation_rate_nxt   = (wr_go && adr == `ADR_INTERPOLATION_RATE) ?
                                    rate_merge[`INTERPOLATION_RATE_W-1:0] : interpolation_rate_r;
  assign serial_output_config_nxt = (wr_go && adr == `ADR_SERIAL) ?
                                    ser_merge[1:0] : serial_output_config_r;

  wire [3:0] status_word;
  assign status_word[`STAT_RATE_OK] = rate_ok;
  assign status_word[`STAT_Q1_OK]   = q1_ok;
  assign status_word[`STAT_Q2_OK]   = q2_ok;
  assign status_word[`STAT_CALIB]   = calib;

  always_comb begin
    case (adr)
      `ADR_CONFIG:   rd_word = {21'h0, primary_config_word_r};
      `ADR_INTERPOLATION_RATE:    rd_word = {18'h0, interpolation_rate_r};
      `ADR_SERIAL:   rd_word = {30'h0, serial_output_config_r};
      `ADR_CNT_ONE:  rd_word = 32'(signed'(channel_one_count));
      `ADR_CNT_TWO:  rd_word = 32'(signed'(channel_two_count));
      `ADR_POSITION: rd_word = 32'(position_result_r);
      `ADR_STATUS:   rd_word = {28'h0, status_word};
      default:       rd_word = coef_hit ? {16'h0, coef_bus} : 32'h0;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      bus_r                  <= BUS_IDLE;
      ack_r                  <= 1'b0;
      dat_r                  <= 32'h0;
      primary_config_word_r  <= `CFG_RESET;
      interpolation_rate_r   <= `INTERPOLATION_RATE_RESET;
      serial_output_config_r <= `SERIAL_RESET;
    end else begin
      bus_r                  <= bus_nxt;
      ack_r                  <= (bus_nxt == BUS_ACK);
      dat_r                  <= rd_go ? rd_word : 32'h0;
      primary_config_word_r  <= primary_config_word_nxt;
      interpolation_rate_r   <= interpolation_rate_nxt;
      serial_output_config_r <= serial_output_config_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  //////////////////////////////////////////////////////////////////////////////
  // correction coefficients

  coef_mem #(
    .DEPTH (16),
    .WIDTH (16),
    .AW    (4)
  ) u_coef (
    .clk     (SYS_CLK),
    .rst_n   (RESETN),
    .wr_en   (coef_wr),
    .wr_addr (WB_ADR_I[5:2]),
    .wr_data (WB_DAT_I[15:0]),
    .addr_a  (WB_ADR_I[5:2]),
    .data_a  (coef_bus),
    .addr_b  (PHASE_CH_ONE[15:12]),
    .data_b  (coef_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // vernier combination

  logic [15:0] ph1_d;
  logic [15:0] ph2_d;
  logic [13:0] fine1_d;

  // pitch in periods: rate shifted by 3 to 6
  wire [2:0]  vshift = {1'b0, vernier_div} + `VDIV_BASE;
  wire [13:0] vernier_pitch = interpolation_rate_r >> vshift;
  // coefficient picked by the coarse sector of channel one
  wire [15:0] diff = ph1_d - ph2_d + coef_q;
  wire [29:0] coarse = frac_scale(diff, vernier_pitch);
  // period index rounded against the fine phase, kept positive
  wire [30:0] k_fx = {1'b0, coarse} + {1'b0, vernier_pitch, 16'h0}
                   - {15'h0, ph1_d} + `FRAC_HALF;
  wire [14:0] k_raw = k_fx[30:16];
  wire [14:0] pitch_x1 = {1'b0, vernier_pitch};
  wire [14:0] pitch_x2 = {vernier_pitch, 1'b0};
  // rounding can land exactly on twice the pitch, so fold twice
  wire [14:0] k_per = (k_raw >= pitch_x2) ? k_raw - pitch_x2 :
                      (k_raw >= pitch_x1) ? k_raw - pitch_x1 : k_raw;
  wire [28:0] abs_full = {14'h0, k_per} * {15'h0, interpolation_rate_r};
  wire [POS_W-1:0] abs_pos = abs_full[POS_W-1:0] + POS_W'(fine1_d);

  localparam int HALF_W = POS_W / 2;

  always_comb begin
    case (position_source_select)
      `SRC_ABS:  position_result_nxt = abs_pos;
      `SRC_CH1:  position_result_nxt = channel_one_count;
      `SRC_CH2:  position_result_nxt = channel_two_count;
      `SRC_BOTH: position_result_nxt = {channel_two_count[HALF_W-1:0],
                                        channel_one_count[HALF_W-1:0]};
      default:   position_result_nxt = abs_pos;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      ph1_d             <= 16'h0;
      ph2_d             <= 16'h0;
      fine1_d           <= 14'h0;
      position_result_r <= '0;
    end else begin
      ph1_d             <= PHASE_CH_ONE;
      ph2_d             <= PHASE_CH_TWO;
      fine1_d           <= fine_one;
      position_result_r <= position_result_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_split_share: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !divider_split_select |-> q2_ok == q1_ok)
    else $error("channel two not using divider one");

  a_rate_flag: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (interpolation_rate_r[2:0] != 3'h0 ||
     (vernier_div == 2'h0 && interpolation_rate_r > 14'h1000)) |-> !rate_ok)
    else $error("invalid rate not flagged");

  a_pos_source: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    position_source_select == 2'h1 |=> position_result_r == $past(channel_one_count))
    else $error("position register not showing channel one");

  a_abs_range: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (position_source_select == 2'h0 && rate_ok) ##1 $stable(interpolation_rate_r)
    |-> k_per < {1'b0, vernier_pitch})
    else $error("vernier period index out of pitch");

  a_write_on_ack: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_go |-> WB_ACK_O)
    else $error("register write outside the ack cycle");

  a_ack_pulse: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");

  a_ack_latency: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (req && bus_r == BUS_IDLE) ##1 req |-> ##1 WB_ACK_O)
    else $error("ack not two edges after request");

endmodule

// ---- rtl/sincos_pkg.sv ----
package sincos_pkg;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } quad_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_ACK  = 3'b100
  } bus_state_t;

  // fraction of a period times a count, 16 fraction bits kept
  function automatic logic [29:0] frac_scale(input logic [15:0] frac,
                                             input logic [13:0] n);
    frac_scale = {14'h0, frac} * {16'h0, n};
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    byte_merge = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        byte_merge[8*i +: 8] = new_w[8*i +: 8];
      end
    end
  endfunction

endpackage

// ---- tb/quad_counter_model.sv ----
`timescale 1ns/1ps
module quad_counter_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // square-wave pair from the device
  input  sincos_pkg::quad_t       quad,
  // decoded position
  output logic signed [23:0]      count,
  output logic                    jump_err
);
  import sincos_pkg::*;

  logic [1:0] prev_r;
  logic [1:0] cur;
  logic [1:0] up_next;
  logic [1:0] dn_next;

  // forward gray order of {a,b}: 00, 10, 11, 01
  assign cur     = {quad.a, quad.b};
  assign up_next = {~prev_r[0], prev_r[1]};
  assign dn_next = {prev_r[0], ~prev_r[1]};

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_r   <= 2'h0;
      count    <= 24'h0;
      jump_err <= 1'b0;
    end else begin
      prev_r <= cur;
      if (cur == up_next) begin
        count <= count + 24'h1;
      end else if (cur == dn_next) begin
        count <= count - 24'h1;
      end else if (cur != prev_r) begin
        // a real counter loses track on a double step
        jump_err <= 1'b1;
      end
    end
  end
endmodule

// ---- tb/sincos_interpolation_vernier_tb.sv ----
`timescale 1ns/1ps
`include "sincos_defs.svh"
module sincos_interpolation_vernier_tb;
  import sincos_pkg::*;

  logic               clk   = 1'b0;
  logic               rst_n = 1'b0;
  logic               cyc   = 1'b0;
  logic               stb   = 1'b0;
  logic               we    = 1'b0;
  logic [7:0]         adr   = 8'h00;
  logic [3:0]         sel   = 4'hf;
  logic [31:0]        wdat  = 32'h0;
  logic [15:0]        ph1   = 16'h0;
  logic [15:0]        ph2   = 16'h0;
  logic [31:0]        rdat;
  logic               ack;
  quad_t              q1;
  quad_t              q2;
  logic signed [23:0] m1;
  logic signed [23:0] m2;
  logic               e1;
  logic               e2;
  logic [31:0]        expq[$];
  int                 mismatches = 0;
  int                 comparisons = 0;
  int                 a1;
  int                 a2;
  logic [31:0]        tc[9] = '{32'h600, 32'h600, 32'h600, 32'h600, 32'h000, 32'h000,
                                32'h6f0, 32'h730, 32'h608};
  logic [31:0]        tr[9] = '{32'h100, 32'h0ff, 32'h2000, 32'h2008, 32'h1000, 32'h1008,
                                32'h808, 32'h808, 32'h800};
  logic [31:0]        ts[9] = '{32'h7, 32'h0, 32'h7, 32'h6, 32'h7, 32'h6, 32'h1, 32'h5, 32'h7};

  always #10 clk = ~clk;

  sincos_interpolation_vernier uut (
    .SYS_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PHASE_CH_ONE(ph1), .PHASE_CH_TWO(ph2),
    .QUADRATURE_OUTPUTS_CH_ONE(q1), .QUADRATURE_OUTPUTS_CH_TWO(q2)
  );
  quad_counter_model far1 (.clk(clk), .rst_n(rst_n), .quad(q1), .count(m1), .jump_err(e1));
  quad_counter_model far2 (.clk(clk), .rst_n(rst_n), .quad(q2), .count(m2), .jump_err(e2));

  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read data is judged by the watcher at the ack edge, we still held there
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      cmp(rdat, expq.pop_front());
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    ph1   <= 16'h0;
    ph2   <= 16'h0;
    a1 = 0;
    a2 = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // steps stay below half a period so direction is never ambiguous
  task automatic sweep(input int n);
    repeat (n) begin
      a1 += $urandom_range(16'h0fff, 0);
      a2 -= $urandom_range(16'h0fff, 0);
      @(posedge clk);
      ph1 <= a1[15:0];
      ph2 <= a2[15:0];
      repeat (140) @(posedge clk);
    end
  endtask

  task automatic check_counts(input int d1, input int d2);
    int c1;
    int c2;
    c1 = a1 >>> (5 + d1);
    c2 = a2 >>> (5 + d2);
    rd(`ADR_CNT_ONE, c1);
    rd(`ADR_CNT_TWO, c2);
    cmp({8'h0, m1}, {8'h0, c1[23:0]});
    cmp({8'h0, m2}, {8'h0, c2[23:0]});
    cmp({30'h0, e1, e2}, 32'h0);
    cmp({31'h0, q1.z}, {31'h0, ((a1[15:0] >> 5) >> d1) == 0});
    wr(`ADR_SERIAL, 32'h1);
    rd(`ADR_POSITION, {8'h0, c1[23:0]});
    wr(`ADR_SERIAL, 32'h2);
    rd(`ADR_POSITION, {8'h0, c2[23:0]});
    wr(`ADR_SERIAL, 32'h3);
    rd(`ADR_POSITION, {8'h0, c2[11:0], c1[11:0]});
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("watchdog expired at %0t", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(94741));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`ADR_CONFIG, 32'h600);
    rd(`ADR_INTERPOLATION_RATE, 32'h800);
    rd(`ADR_SERIAL, 32'h0);
    rd(8'h20, 32'h0);
    wr(`ADR_CNT_ONE, 32'h55);
    rd(`ADR_CNT_ONE, 32'h0);
    rd(`ADR_POSITION, 32'h0);
    wr(8'h40, 32'h0800);
    rd(8'h40, 32'h0800);
    rd(`ADR_POSITION, 32'h800);
    for (int i = 0; i < 9; i++) begin
      wr(`ADR_CONFIG, tc[i]);
      wr(`ADR_INTERPOLATION_RATE, tr[i]);
      rd(`ADR_STATUS, ts[i]);
    end
    $display("test register map done");
    for (int t = 0; t < 4; t++) begin
      do_reset();
      wr(`ADR_CONFIG, 32'h600 | ((t % 2) << 8) | ((3 - t) << 6) | (t << 4));
      sweep(8);
      check_counts(t, (t % 2) ? 3 - t : t);
      $display("test counting divider %0d done", t);
    end
    do_reset();
    wr(`ADR_CONFIG, 32'h605);
    for (int k = 0; k < 4; k++) begin
      a1 = k * 16384 + 256;
      a2 = a1;
      @(posedge clk);
      ph1 <= a1[15:0];
      ph2 <= a2[15:0];
      repeat (600) @(posedge clk);
      cmp({30'h0, q1.a, q1.b}, {30'h0, ~a1[15], ~(a1[15] ^ a1[14])});
      cmp({30'h0, q2.a, q2.b}, {30'h0, ~a2[15], ~(a2[15] ^ a2[14])});
    end
    rd(`ADR_CNT_ONE, a1 >>> 5);
    rd(`ADR_CNT_TWO, a2 >>> 5);
    rd(`ADR_STATUS, 32'hf);
    $display("test calibration done");
    print_verdict();
  end
endmodule
